// file: core/cafg_pkg.sv
`default_nettype none
package cafg_pkg;
	// Serial target address: value is arbitrary
	localparam logic [6:0] DEV_ADDR      = 7'h2A;
	localparam logic [7:0] REG_AUX_CFG   = 8'h03;
	localparam logic [7:0] REG_FAULT     = 8'h04;
	localparam logic [1:0] AUX_CFG_RST   = 2'h0;
	localparam logic [5:0] FAULT_RST     = 6'h02;
	localparam int         CFG_SINGLE    = 1;
	localparam int         CFG_BLANK     = 0;
	localparam int         FLG_RETRY     = 5;
	localparam int         FLG_OVERCUR   = 4;
	localparam int         FLG_WARN      = 3;
	localparam int         FLG_OFF       = 2;
	localparam int         FLG_UNDERV    = 1;
	localparam int         FLG_OVERV     = 0;
	localparam int         NUM_FLAGS     = 6;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage
`default_nettype wire

// file: core/cafg_event_flag.sv
`timescale 1ns/1ps
`default_nettype none
module cafg_event_flag #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic ce_i,
	// Event and clear
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_o
);
	logic flag_r;

	// A set in the clearing cycle survives, so no event is lost
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			flag_r <= RST_VAL;
		end else if (ce_i) begin
			flag_r <= set_i | (flag_r & ~clr_i);
		end
	end

	assign flag_o = flag_r;
endmodule
`default_nettype wire

// file: core/cafg_top.sv
`timescale 1ns/1ps
`default_nettype none
module cafg_top (
	// Clock, reset, enable
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic ce_i,
	// Two-wire serial bus
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe_o,
	// Fault events from the converter
	input  wire logic evt_retry_i,
	input  wire logic overcurrent_flag_i,
	input  wire logic overtemp_warning_flag_i,
	input  wire logic overtemp_off_flag_i,
	input  wire logic undervolt_flag_i,
	input  wire logic overvolt_flag_i,
	// Power-good path
	input  wire logic window_ok_i,
	input  wire logic setpoint_slewing_i,
	output logic      power_good_output_o,
	output logic      power_good_output_oe_o,
	// Standalone-operation controls
	input  wire logic clock_follow_src_i,
	output logic      en_pulldown_o,
	output logic      clock_follow_output_o
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_RACK,
		ST_WDAT, ST_WACK, ST_RDAT, ST_MACK
	} cafg_state_t;

	cafg_state_t state_r;
	logic        scl_q_r;
	logic        sda_q_r;
	logic [3:0]  cnt_r;
	logic [7:0]  shift_r;
	logic [7:0]  ptr_r;
	logic        rw_r;
	logic        mack_r;
	logic        sda_oe_r;
	logic [1:0]  cfg_r;
	logic [5:0]  evt_vec;
	logic [5:0]  flags_w;
	logic [7:0]  rd_byte;
	logic        scl_rise;
	logic        scl_fall;
	logic        bus_start;
	logic        bus_stop;
	logic        rd_load;
	logic        stat_clr;
	logic        wr_cfg;

	assign scl_rise  = scl_i & ~scl_q_r;
	assign scl_fall  = ~scl_i & scl_q_r;
	assign bus_start = scl_i & scl_q_r & sda_q_r & ~sda_i;
	assign bus_stop  = scl_i & scl_q_r & ~sda_q_r & sda_i;

	// A byte is loaded for the host after the ack of a read address or a host ack
	assign rd_load  = scl_fall & ((state_r == ST_AACK & rw_r) | (state_r == ST_MACK & mack_r));
	assign stat_clr = rd_load & (ptr_r == cafg_pkg::REG_FAULT);
	assign wr_cfg   = scl_fall & (state_r == ST_WDAT) & (cnt_r == cafg_pkg::BITS_PER_BYTE)
		& (ptr_r == cafg_pkg::REG_AUX_CFG);

	always_comb begin
		rd_byte = 8'h00;
		if (ptr_r == cafg_pkg::REG_AUX_CFG) begin
			rd_byte = {6'h00, cfg_r};
		end else if (ptr_r == cafg_pkg::REG_FAULT) begin
			rd_byte = {2'h0, flags_w};
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else if (ce_i) begin
			scl_q_r <= scl_i;
			sda_q_r <= sda_i;
		end
	end

	// Serial target: shifts on SCL rise, drives SDA after SCL fall
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r  <= ST_IDLE;
			cnt_r    <= 4'h0;
			shift_r  <= 8'h00;
			ptr_r    <= 8'h00;
			rw_r     <= 1'b0;
			mack_r   <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (ce_i) begin
			if (bus_start) begin
				state_r  <= ST_ADDR;
				cnt_r    <= 4'h0;
				sda_oe_r <= 1'b0;
			end else if (bus_stop) begin
				state_r  <= ST_IDLE;
				sda_oe_r <= 1'b0;
			end else if (scl_rise) begin
				case (state_r)
					ST_ADDR, ST_REG, ST_WDAT: begin
						shift_r <= {shift_r[6:0], sda_i};
						cnt_r   <= cnt_r + 4'h1;
					end
					ST_RDAT: cnt_r <= cnt_r + 4'h1;
					ST_MACK: mack_r <= ~sda_i;
					default: ;
				endcase
			end else if (scl_fall) begin
				case (state_r)
					ST_ADDR: begin
						if (cnt_r == cafg_pkg::BITS_PER_BYTE) begin
							if (shift_r[7:1] == cafg_pkg::DEV_ADDR) begin
								rw_r     <= shift_r[0];
								sda_oe_r <= 1'b1;
								state_r  <= ST_AACK;
							end else begin
								state_r <= ST_IDLE;
							end
						end
					end
					ST_AACK, ST_MACK: begin
						cnt_r <= 4'h0;
						if (rd_load) begin
							shift_r  <= rd_byte;
							sda_oe_r <= ~rd_byte[7];
							ptr_r    <= ptr_r + 8'h01;
							state_r  <= ST_RDAT;
						end else begin
							sda_oe_r <= 1'b0;
							state_r  <= (state_r == ST_AACK) ? ST_REG : ST_IDLE;
						end
					end
					ST_REG: begin
						if (cnt_r == cafg_pkg::BITS_PER_BYTE) begin
							ptr_r    <= shift_r;
							sda_oe_r <= 1'b1;
							state_r  <= ST_RACK;
						end
					end
					ST_RACK, ST_WACK: begin
						cnt_r    <= 4'h0;
						sda_oe_r <= 1'b0;
						state_r  <= ST_WDAT;
					end
					ST_WDAT: begin
						if (cnt_r == cafg_pkg::BITS_PER_BYTE) begin
							ptr_r    <= ptr_r + 8'h01;
							sda_oe_r <= 1'b1;
							state_r  <= ST_WACK;
						end
					end
					ST_RDAT: begin
						if (cnt_r == cafg_pkg::BITS_PER_BYTE) begin
							sda_oe_r <= 1'b0;
							state_r  <= ST_MACK;
						end else begin
							shift_r  <= {shift_r[6:0], 1'b0};
							sda_oe_r <= ~shift_r[6];
						end
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// Open-drain data: only the enable ever moves, the value stays low
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sda_o <= 1'b0;
		end else if (ce_i) begin
			sda_o <= 1'b0;
		end
	end

	assign sda_oe_o = sda_oe_r;

	// Upper bits are never stored, so they read as zero whatever is written
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cfg_r <= cafg_pkg::AUX_CFG_RST;
		end else if (ce_i && wr_cfg) begin
			cfg_r <= shift_r[1:0];
		end
	end

	assign evt_vec[cafg_pkg::FLG_RETRY]   = evt_retry_i;
	assign evt_vec[cafg_pkg::FLG_OVERCUR] = overcurrent_flag_i;
	assign evt_vec[cafg_pkg::FLG_WARN]    = overtemp_warning_flag_i;
	assign evt_vec[cafg_pkg::FLG_OFF]     = overtemp_off_flag_i;
	assign evt_vec[cafg_pkg::FLG_UNDERV]  = undervolt_flag_i;
	assign evt_vec[cafg_pkg::FLG_OVERV]   = overvolt_flag_i;

	for (genvar k = 0; k < cafg_pkg::NUM_FLAGS; k++) begin : g_flag
		cafg_event_flag #(
			.RST_VAL (cafg_pkg::FAULT_RST[k])
		) u_flag (
			.clk_i     (clk_i),
			.sys_rst_i (sys_rst_i),
			.ce_i      (ce_i),
			.set_i     (evt_vec[k]),
			.clr_i     (stat_clr),
			.flag_o    (flags_w[k])
		);
	end

	// Open-drain good flag: pulled low when bad, released when good or blanked
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			power_good_output_o    <= 1'b0;
			power_good_output_oe_o <= 1'b1;
		end else if (ce_i) begin
			power_good_output_o    <= 1'b0;
			power_good_output_oe_o <= ~(window_ok_i
				| (cfg_r[cafg_pkg::CFG_BLANK] & setpoint_slewing_i));
		end
	end

	// Stacked setups rely on the host leaving the standalone bit clear
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			en_pulldown_o         <= 1'b1;
			clock_follow_output_o <= 1'b0;
		end else if (ce_i) begin
			en_pulldown_o         <= ~cfg_r[cafg_pkg::CFG_SINGLE];
			clock_follow_output_o <= ~cfg_r[cafg_pkg::CFG_SINGLE] & clock_follow_src_i;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_pulldown_mode: assert property ($past(ce_i)
		|-> en_pulldown_o == !$past(cfg_r[cafg_pkg::CFG_SINGLE]))
		else $error("Pulldown does not follow standalone bit");
	a_follow_off: assert property (ce_i && cfg_r[cafg_pkg::CFG_SINGLE]
		|=> !clock_follow_output_o)
		else $error("Clock-follow driven in standalone mode");
	a_good_follows: assert property (ce_i && !cfg_r[cafg_pkg::CFG_BLANK]
		|=> power_good_output_oe_o == !$past(window_ok_i))
		else $error("Good flag does not track comparator");
	a_good_blanked: assert property (ce_i && cfg_r[cafg_pkg::CFG_BLANK] && setpoint_slewing_i
		|=> !power_good_output_oe_o)
		else $error("Good flag pulled low while blanked");
	a_cfg_upper: assert property (ce_i && rd_load && ptr_r == cafg_pkg::REG_AUX_CFG
		|=> shift_r[7:2] == 6'h00)
		else $error("Config upper bits read nonzero");
	a_stat_upper: assert property (ce_i && rd_load && ptr_r == cafg_pkg::REG_FAULT
		|=> shift_r[7:6] == 2'h0)
		else $error("Status upper bits read nonzero");
	a_event_sets: assert property (ce_i && evt_vec != 6'h00 |=> (flags_w & $past(evt_vec)) == $past(evt_vec))
		else $error("Event did not set its flag");
	a_read_clears: assert property (ce_i && stat_clr && evt_vec == 6'h00 |=> flags_w == 6'h00)
		else $error("Status read did not clear flags");
	a_flag_reset: assert property (disable iff (1'b0) $fell(sys_rst_i) |-> flags_w == cafg_pkg::FAULT_RST)
		else $error("Status reset value wrong");
	a_cfg_write: assert property (ce_i && wr_cfg |=> cfg_r == $past(shift_r[1:0]))
		else $error("Config write not stored");
endmodule
`default_nettype wire

// file: test/cafg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cafg_host_model (
	// Clock
	input  wire logic clk_i,
	// Bus lines
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Each bus phase spans four clocks, four times the minimum the target needs
	task automatic hold();
		repeat (4) @(posedge clk_i);
	endtask
	// Data rises while clock is low, so this also makes a repeated start
	task automatic start();
		sda_o <= 1'b1;
		hold();
		scl_o <= 1'b1;
		hold();
		sda_o <= 1'b0;
		hold();
		scl_o <= 1'b0;
		hold();
	endtask
	task automatic stop();
		sda_o <= 1'b0;
		hold();
		scl_o <= 1'b1;
		hold();
		sda_o <= 1'b1;
		hold();
	endtask
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_o <= tx[i];
			hold();
			scl_o <= 1'b1;
			hold();
			rx[i] = sda_i;
			scl_o <= 1'b0;
			hold();
		end
	endtask
endmodule
`default_nettype wire

// file: test/test_converter_aux_config_and_fault_flags.sv
`timescale 1ns/1ps
`default_nettype none
module test_converter_aux_config_and_fault_flags;
	logic        clk;
	logic        sys_rst;
	logic        ce;
	logic [5:0]  ev;
	logic        win;
	logic        slew;
	logic        src;
	logic        scl;
	logic        hsda;
	logic        dsda;
	logic        sda_oe;
	logic        good;
	logic        good_oe;
	logic        pd;
	logic        cfo;
	logic [31:0] seed;
	logic [7:0]  d;
	logic [7:0]  d2;
	int          errors;
	int          n_tests;
	// Pull-up on the data wire: low if either side pulls it
	wire sda = hsda & (sda_oe ? dsda : 1'b1);
	cafg_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
	cafg_top DUT (.clk_i(clk), .sys_rst_i(sys_rst), .ce_i(ce), .scl_i(scl), .sda_i(sda),
		.sda_o(dsda), .sda_oe_o(sda_oe), .evt_retry_i(ev[5]), .overcurrent_flag_i(ev[4]),
		.overtemp_warning_flag_i(ev[3]), .overtemp_off_flag_i(ev[2]), .undervolt_flag_i(ev[1]),
		.overvolt_flag_i(ev[0]), .window_ok_i(win), .setpoint_slewing_i(slew),
		.power_good_output_o(good), .power_good_output_oe_o(good_oe), .clock_follow_src_i(src),
		.en_pulldown_o(pd), .clock_follow_output_o(cfo));
	initial clk = 1'b0;
	always #12.5 clk = ~clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] pins(input logic [1:0] c, input logic w, input logic s, input logic f);
		return {5'h00, ~(w | (c[0] & s)), ~c[1], f & ~c[1]};
	endfunction
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		logic [8:0] r;
		host.start();
		host.xfer({cafg_pkg::DEV_ADDR, 1'b0, 1'b1}, r);
		check("address ack", 8'h00, {7'h00, r[0]});
		host.xfer({a, 1'b1}, r);
		host.xfer({v, 1'b1}, r);
		host.stop();
	endtask
	task automatic rreg(input logic [7:0] a, output logic [7:0] v);
		logic [8:0] r;
		host.start();
		host.xfer({cafg_pkg::DEV_ADDR, 1'b0, 1'b1}, r);
		host.xfer({a, 1'b1}, r);
		host.start();
		host.xfer({cafg_pkg::DEV_ADDR, 1'b1, 1'b1}, r);
		host.xfer({8'hff, 1'b1}, r);
		v = r[8:1];
		host.stop();
	endtask
	// Two-byte read: host acks the first byte, so the byte at the moved-on pointer follows
	task automatic rpair(input logic [7:0] a, output logic [7:0] v0, output logic [7:0] v1);
		logic [8:0] r;
		host.start();
		host.xfer({cafg_pkg::DEV_ADDR, 1'b0, 1'b1}, r);
		host.xfer({a, 1'b1}, r);
		host.start();
		host.xfer({cafg_pkg::DEV_ADDR, 1'b1, 1'b1}, r);
		host.xfer({8'hff, 1'b0}, r);
		v0 = r[8:1];
		host.xfer({8'hff, 1'b1}, r);
		v1 = r[8:1];
		host.stop();
	endtask
	task automatic close_out();
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		close_out();
	end
	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		ev = 6'h00;
		win = 1'b0;
		slew = 1'b0;
		src = 1'b0;
		seed = 32'h71f4_676b;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		check("pulldown", 8'h01, {7'h00, pd});
		rreg(cafg_pkg::REG_FAULT, d);
		check("status reset", 8'h02, d);
		rreg(cafg_pkg::REG_FAULT, d);
		check("status cleared", 8'h00, d);
		rreg(cafg_pkg::REG_AUX_CFG, d);
		check("config reset", 8'h00, d);
		rreg(8'h05, d);
		check("unmapped", 8'h00, d);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			ev <= 6'(1 << i);
			@(posedge clk);
			ev <= 6'h00;
			rreg(cafg_pkg::REG_FAULT, d);
			check("flag", 8'(1 << i), d);
			rreg(cafg_pkg::REG_FAULT, d);
			check("flag cleared", 8'h00, d);
		end
		// An event still present across the read sets its flag again
		ev <= 6'h10;
		rreg(cafg_pkg::REG_FAULT, d);
		rreg(cafg_pkg::REG_FAULT, d);
		check("persisting flag", 8'h10, d);
		for (int c = 0; c < 4; c++) begin
			// Single device, so the standalone bit may be set; upper bits stay zero
			wreg(cafg_pkg::REG_AUX_CFG, {6'h00, 2'(c)});
			rreg(cafg_pkg::REG_AUX_CFG, d);
			check("config", {6'h00, 2'(c)}, d);
			for (int k = 0; k < 12; k++) begin
				seed = lfsr(seed);
				{win, slew, src, ev} <= seed[8:0];
				repeat (2) @(posedge clk);
				#1;
				check("pins", pins(2'(c), win, slew, src), {4'h0, good, good_oe, pd, cfo});
				@(posedge clk);
			end
		end
		// Drop random leftovers, then read config and status in one burst
		ev <= 6'h00;
		rreg(cafg_pkg::REG_FAULT, d);
		ev <= 6'h05;
		@(posedge clk);
		ev <= 6'h00;
		rpair(cafg_pkg::REG_AUX_CFG, d, d2);
		check("burst config", 8'h03, d);
		check("burst status", 8'h05, d2);
		rreg(cafg_pkg::REG_FAULT, d);
		check("burst cleared", 8'h00, d);
		// Enable low must hold the good pin although the comparator moves
		win <= 1'b0;
		slew <= 1'b0;
		repeat (2) @(posedge clk);
		ce <= 1'b0;
		win <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check("frozen good", 8'h01, {7'h00, good_oe});
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check("resumed good", 8'h00, {7'h00, good_oe});
		close_out();
	end
endmodule
`default_nettype wire
